// [core/dssc_pkg.sv]
`default_nettype none
package dssc_pkg;
  // Timing base
  localparam int CLK_HZ          = 100_000_000;         // System clock rate
  localparam int WD_TIMEOUT_MS   = 310;                 // Watchdog toggle window
  localparam int IN_TIMEOUT_MS   = 250;                 // Direct input idle time
  localparam int WAKE_READY_US   = 50;                  // Start-up settle time
  localparam int PWM_MAX_HZ      = 1000;                // Highest output PWM rate
  localparam int PWM_STEPS       = 256;                 // Steps per PWM period
  localparam int WD_CYCLES       = (CLK_HZ / 1000) * WD_TIMEOUT_MS;
  localparam int IN_CYCLES       = (CLK_HZ / 1000) * IN_TIMEOUT_MS;
  localparam int WAKE_CYCLES     = (CLK_HZ / 1_000_000) * WAKE_READY_US;
  // Round up so the internal PWM never exceeds its top rate
  localparam int INT_DIV_CYCLES  = (CLK_HZ + PWM_MAX_HZ * PWM_STEPS - 1) / (PWM_MAX_HZ * PWM_STEPS);
  localparam int CNT_W           = 25;                  // Width of long timers
  localparam int DIV_W           = 9;                   // Width of internal divider
  // Frame layout
  localparam logic [4:0] FRAME_BITS = 5'h10;            // Bits in one frame
  localparam logic [3:0] ADDR_GCR   = 4'h0;             // Global configuration
  localparam logic [3:0] ADDR_PWM0  = 4'h1;             // Pulse width, channel 0
  localparam logic [3:0] ADDR_PWM1  = 4'h2;             // Pulse width, channel 1
  localparam logic [3:0] ADDR_CONF0 = 4'h3;             // Configuration, channel 0
  localparam logic [3:0] ADDR_CONF1 = 4'h4;             // Configuration, channel 1
  localparam logic [3:0] ADDR_RDSEL = 4'h5;             // Read-back selector
  // Read-back indices
  localparam logic [3:0] RB_STATUS  = 4'h0;
  localparam logic [3:0] RB_PWM0    = 4'h1;
  localparam logic [3:0] RB_PWM1    = 4'h2;
  localparam logic [3:0] RB_CONF0   = 4'h3;
  localparam logic [3:0] RB_CONF1   = 4'h4;
  localparam logic [3:0] RB_GCR     = 4'h5;
  localparam logic [3:0] RB_FAULT0  = 4'h6;
  localparam logic [3:0] RB_FAULT1  = 4'h7;
  localparam logic [3:0] RB_COUNT   = 4'hd;             // Indices from 13 up return the previous frame
  localparam logic [1:0] DEFAULT_CODE = 2'h0;           // Default delay and slew

  // Operating modes, Gray coded along sleep-normal-failsafe-fault
  typedef enum logic [1:0] {
    MODE_SLEEP    = 2'b00,
    MODE_NORMAL   = 2'b01,
    MODE_FAILSAFE = 2'b11,
    MODE_FAULT    = 2'b10
  } dssc_mode_t;

  // One received frame
  typedef struct packed {
    logic       watchdog_toggle_bit;                    // D15
    logic [1:0] spare;                                  // D14..D13
    logic [3:0] addr;                                   // D12..D9
    logic [8:0] data;                                   // D8..D0
  } dssc_frame_t;

  // Pulse-width register
  typedef struct packed {
    logic       on_bit;                                 // D8
    logic [7:0] duty;                                   // D7..D0
  } dssc_pwm_t;

  // Channel configuration register
  typedef struct packed {
    logic [1:0] pwm_prescaler;                          // D8..D7
    logic [1:0] slew;                                   // D6..D5
    logic [1:0] delay;                                  // D4..D3
    logic       dir_disable;                            // D2
    logic       clk_int;                                // D1
    logic       pwm_en;                                 // D0
  } dssc_conf_t;

  // Global configuration register
  typedef struct packed {
    logic [3:0] spare_hi;                               // D8..D5
    logic       watchdog_disable;                       // D4
    logic       vdd_fail_en;                            // D3
    logic [2:0] spare_lo;                               // D2..D0
  } dssc_gcr_t;

  // Per-channel fault causes
  typedef struct packed {
    logic oc;                                           // Overcurrent
    logic ot;                                           // Overtemperature
    logic sc;                                           // Severe short
    logic ol;                                           // Open load
  } dssc_chfault_t;
endpackage : dssc_pkg
`default_nettype wire

// [core/dssc_core.sv]
`timescale 1ns/1ps
`default_nettype none
module dssc_core #(
  parameter int WD_CYCLES_P   = dssc_pkg::WD_CYCLES,    // Watchdog window in cycles
  parameter int IN_CYCLES_P   = dssc_pkg::IN_CYCLES,    // Input idle time in cycles
  parameter int WAKE_CYCLES_P = dssc_pkg::WAKE_CYCLES   // Settle time in cycles
) (
  input  wire logic                      clock_in,               // System clock
  input  wire logic                      rst_in,                 // Synchronous reset
  input  wire logic                      sclk_in,                // Serial clock
  input  wire logic                      chip_select_n_in,       // Frame select, low active
  input  wire logic                      sdi_in,                 // Serial data in
  input  wire logic                      reset_in_n_in,          // Wake/reset pin
  input  wire logic [1:0]                direct_in,              // Direct channel inputs
  input  wire logic                      ext_pwm_clk_in,         // External PWM clock
  input  wire logic                      vdd_ok_in,              // Interface supply good
  input  wire dssc_pkg::dssc_chfault_t [1:0] chan_fault_in,      // Channel fault causes
  input  wire logic                      uv_fault_in,            // Undervoltage
  input  wire logic                      ov_fault_in,            // Overvoltage
  output logic                           sdo_out,                // Serial data out
  output logic                           sdo_oe_out,             // Serial output drive enable
  output logic                           failsafe_out_n_out,     // Fail-safe pin level (0)
  output logic                           failsafe_oe_out,        // Fail-safe pin pulls low
  output logic [1:0]                     hson_out,               // Channel on targets
  output logic                           normal_mode_flag_out,   // Normal mode flag
  output dssc_pkg::dssc_mode_t           mode_out                // Operating mode
);
  import dssc_pkg::*;

  // All state of the block
  typedef struct packed {
    dssc_mode_t              mode;
    logic                    sclk_q;
    logic                    csn_q;
    logic                    reset_in_n_q;
    logic                    ext_q;
    logic [1:0]              din_q;
    logic [15:0]             shift_in;
    logic [4:0]              bit_cnt;
    logic [15:0]             shift_out;
    logic [15:0]             last_frame;
    dssc_gcr_t               gcr;
    dssc_pwm_t  [1:0]        pwm;
    dssc_conf_t [1:0]        conf;
    logic [3:0]              rdsel;
    dssc_chfault_t [1:0]     fault_reg;
    logic [1:0]              glob_fault;
    logic                    wd_last;
    logic                    wd_armed;
    logic                    wd_timeout;
    logic [CNT_W-1:0]        wd_cnt;
    logic [1:0]              in_on;
    logic [1:0][CNT_W-1:0]   idle_cnt;
    logic                    wake_q;
    logic [CNT_W-1:0]        ready_cnt;
    logic                    ready;
    logic [DIV_W-1:0]        int_div;
    logic [1:0][2:0]         pre_cnt;
    logic [1:0][7:0]         pwm_cnt;
    logic                    sdo;
    logic                    sdo_oe;
    logic                    fs_oe;
    logic [1:0]              hson;
    logic                    nm;
  } dssc_state_t;

  dssc_state_t s;        // Registered state
  dssc_state_t next_s;   // Next state

  // Read-back word for a given index; unused indices read zero
  function automatic logic [15:0] read_back(input dssc_state_t st, input logic [3:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      RB_STATUS: w = {8'h00, st.glob_fault, st.hson, (|st.fault_reg[1]), (|st.fault_reg[0]), st.mode};
      RB_PWM0:   w = {7'h00, st.pwm[0]};
      RB_PWM1:   w = {7'h00, st.pwm[1]};
      RB_CONF0:  w = {7'h00, st.conf[0]};
      RB_CONF1:  w = {7'h00, st.conf[1]};
      RB_GCR:    w = {7'h00, st.gcr};
      RB_FAULT0: w = {12'h000, st.fault_reg[0]};
      RB_FAULT1: w = {12'h000, st.fault_reg[1]};
      default: begin
        // Indices from RB_COUNT up return the previous frame; 8 to 12 read zero
        if (idx >= RB_COUNT) begin
          w = st.last_frame;
        end
      end
    endcase
    return w;
  endfunction

  // Next-state logic
  always_comb begin
    dssc_frame_t f;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        ext_rise;
    logic        wake;
    logic        fault;
    logic        fs;
    logic        pulse;
    logic        int_tick;
    logic        tick;
    logic [7:0]  phase;
    logic [2:0]  mask;
    f         = '0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_fall   = 1'b0;
    cs_rise   = 1'b0;
    ext_rise  = 1'b0;
    wake      = 1'b0;
    fault     = 1'b0;
    fs        = 1'b0;
    pulse     = 1'b0;
    int_tick  = 1'b0;
    tick      = 1'b0;
    phase     = 8'h00;
    mask      = 3'h0;
    next_s    = s;

    // Edge detection on the sampled pins
    next_s.sclk_q = sclk_in;
    next_s.csn_q  = chip_select_n_in;
    next_s.reset_in_n_q = reset_in_n_in;
    next_s.ext_q  = ext_pwm_clk_in;
    next_s.din_q  = direct_in;
    sclk_rise = sclk_in & ~s.sclk_q & ~chip_select_n_in;
    sclk_fall = ~sclk_in & s.sclk_q & ~chip_select_n_in;
    cs_fall   = ~chip_select_n_in & s.csn_q;
    cs_rise   = chip_select_n_in & ~s.csn_q;
    ext_rise  = ext_pwm_clk_in & ~s.ext_q;

    // Direct input activity; a held-high input counts as activity
    for (int c = 0; c < 2; c++) begin
      if (direct_in[c] || (direct_in[c] != s.din_q[c])) begin
        next_s.idle_cnt[c] = '0;
        next_s.in_on[c]    = 1'b1;
      end else if (s.idle_cnt[c] >= CNT_W'(IN_CYCLES_P - 1)) begin
        next_s.in_on[c]    = 1'b0;
      end else begin
        next_s.idle_cnt[c] = s.idle_cnt[c] + 1'b1;
      end
    end

    // Mode inputs
    wake  = reset_in_n_in | s.in_on[0] | s.in_on[1];
    fault = (|chan_fault_in[0]) | (|chan_fault_in[1]) | uv_fault_in | ov_fault_in;
    fs    = (~vdd_ok_in & s.gcr.vdd_fail_en) | (s.wd_timeout & ~s.gcr.watchdog_disable);
    next_s.wake_q = wake;

    // Mode priority: sleep, fault, fail-safe, normal
    if (!wake) begin
      next_s.mode = MODE_SLEEP;
    end else if (fault) begin
      next_s.mode = MODE_FAULT;
    end else if (fs) begin
      next_s.mode = MODE_FAILSAFE;
    end else begin
      next_s.mode = MODE_NORMAL;
    end
    next_s.nm = wake & ~fs & ~fault;

    // Sticky fault bits; a new fault beats the clear by read-back
    for (int c = 0; c < 2; c++) begin
      if (cs_fall && (s.rdsel == ((c == 0) ? RB_FAULT0 : RB_FAULT1))) begin
        next_s.fault_reg[c] = '0;
      end
      next_s.fault_reg[c] = next_s.fault_reg[c] | chan_fault_in[c];
    end
    if (cs_fall && (s.rdsel == RB_STATUS)) begin
      next_s.glob_fault = '0;
    end
    next_s.glob_fault = next_s.glob_fault | {uv_fault_in, ov_fault_in};

    // Serial receive: shift on falling clock edges
    if (cs_fall) begin
      next_s.bit_cnt   = '0;
      next_s.shift_out = read_back(s, s.rdsel);
      next_s.sdo       = next_s.shift_out[15];
    end
    if (sclk_fall) begin
      next_s.shift_in = {s.shift_in[14:0], sdi_in};
      if (s.bit_cnt <= FRAME_BITS) begin
        next_s.bit_cnt = s.bit_cnt + 1'b1;
      end
    end
    // Serial transmit: next bit on rising clock edges
    if (sclk_rise) begin
      next_s.shift_out = {s.shift_out[14:0], 1'b0};
      next_s.sdo       = s.shift_out[14];
    end
    // Drive only inside a frame and with the interface supply up
    next_s.sdo_oe = ~chip_select_n_in & vdd_ok_in;

    // Watchdog: restarts on each toggle of the first frame bit
    if (reset_in_n_in && !s.reset_in_n_q) begin
      next_s.wd_cnt     = '0;
      next_s.wd_armed   = vdd_ok_in;
      next_s.wd_timeout = 1'b0;
    end else if (s.wd_armed && reset_in_n_in && !s.wd_timeout) begin
      if (s.wd_cnt >= CNT_W'(WD_CYCLES_P - 1)) begin
        next_s.wd_timeout = 1'b1;
      end else begin
        next_s.wd_cnt = s.wd_cnt + 1'b1;
      end
    end

    // Frame commit on the chip select rising edge
    f = dssc_frame_t'(s.shift_in);
    if (cs_rise && (s.bit_cnt == FRAME_BITS)) begin
      next_s.last_frame = s.shift_in;
      next_s.wd_last    = f.watchdog_toggle_bit;
      if (f.watchdog_toggle_bit != s.wd_last) begin
        next_s.wd_cnt = '0;
      end
      if (s.mode == MODE_FAILSAFE) begin
        // A frame with the first bit set re-opens the link; writes wait for the next
        if (f.watchdog_toggle_bit) begin
          next_s.wd_timeout = 1'b0;
          next_s.wd_cnt     = '0;
        end
      end else if (s.mode != MODE_SLEEP) begin
        case (f.addr)
          ADDR_GCR:   next_s.gcr     = dssc_gcr_t'(f.data);
          ADDR_PWM0:  next_s.pwm[0]  = dssc_pwm_t'(f.data);
          ADDR_PWM1:  next_s.pwm[1]  = dssc_pwm_t'(f.data);
          ADDR_CONF0: next_s.conf[0] = dssc_conf_t'(f.data);
          ADDR_CONF1: next_s.conf[1] = dssc_conf_t'(f.data);
          ADDR_RDSEL: next_s.rdsel   = f.data[3:0];
          default: begin
            // Unassigned addresses only feed the watchdog and the previous-frame read-back
          end
        endcase
      end
    end

    // Internal PWM step clock
    if (s.int_div >= DIV_W'(INT_DIV_CYCLES - 1)) begin
      next_s.int_div = '0;
      int_tick       = 1'b1;
    end else begin
      next_s.int_div = s.int_div + 1'b1;
    end

    // Per-channel PWM counters and switch targets
    for (int c = 0; c < 2; c++) begin
      tick = s.conf[c].clk_int ? int_tick : ext_rise;
      mask = 3'((4'h1 << s.conf[c].pwm_prescaler) - 4'h1);
      if (tick) begin
        next_s.pre_cnt[c] = s.pre_cnt[c] + 1'b1;
        if ((s.pre_cnt[c] & mask) == mask) begin
          next_s.pre_cnt[c] = '0;
          next_s.pwm_cnt[c] = s.pwm_cnt[c] + 1'b1;
        end
      end
      // Turn-on delay shifts the pulse by quarter periods
      phase = s.pwm_cnt[c] - {s.conf[c].delay, 6'h00};
      pulse = phase < s.pwm[c].duty;
      case (s.mode)
        MODE_NORMAL: begin
          next_s.hson[c] = s.ready &
            ((direct_in[c] & ~s.conf[c].dir_disable) |
             (s.pwm[c].on_bit & pulse & s.conf[c].pwm_en) |
             (s.pwm[c].on_bit & ~s.conf[c].pwm_en));
        end
        MODE_FAILSAFE: next_s.hson[c] = direct_in[c];
        default:       next_s.hson[c] = 1'b0;
      endcase
    end

    // Wake-up settle timer
    if (!s.ready) begin
      if (s.ready_cnt >= CNT_W'(WAKE_CYCLES_P - 1)) begin
        next_s.ready = 1'b1;
      end else begin
        next_s.ready_cnt = s.ready_cnt + 1'b1;
      end
    end

    // Fail-safe pin pulls low while in fail-safe
    next_s.fs_oe = (next_s.mode == MODE_FAILSAFE);

    // Register reset on wake-up, in sleep, on entering fail-safe and on leaving it for normal
    if ((wake && !s.wake_q) || !wake ||
        ((next_s.mode == MODE_FAILSAFE) && (s.mode != MODE_FAILSAFE)) ||
        ((next_s.mode == MODE_NORMAL) && (s.mode == MODE_FAILSAFE))) begin
      next_s.gcr   = '0;
      next_s.pwm   = '0;
      next_s.conf  = '0;
      next_s.rdsel = RB_STATUS;
    end
    if (wake && !s.wake_q) begin
      next_s.ready     = 1'b0;
      next_s.ready_cnt = '0;
    end
    if (!wake) begin
      next_s.hson = 2'b00;
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s          <= '0;
      s.csn_q    <= 1'b1;
      s.mode     <= MODE_SLEEP;
      s.rdsel    <= RB_STATUS;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from state flops, except the fail-safe pin level, tied to 0
  assign sdo_out              = s.sdo;
  assign sdo_oe_out           = s.sdo_oe;
  assign failsafe_out_n_out   = 1'b0;
  assign failsafe_oe_out      = s.fs_oe;
  assign hson_out             = s.hson;
  assign normal_mode_flag_out = s.nm;
  assign mode_out             = s.mode;
endmodule // dssc_core
`default_nettype wire

// [verif/dssc_core_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module dssc_core_monitor
  import dssc_pkg::*;
#(
  parameter int WD_CYCLES_P   = 1,      // Watchdog window
  parameter int IN_CYCLES_P   = 1,      // Input idle time
  parameter int WAKE_CYCLES_P = 1       // Settle time
) (
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic       sclk_in,
  input wire logic       chip_select_n_in,
  input wire logic       reset_in_n_in,
  input wire logic [1:0] direct_in,
  input wire logic       vdd_ok_in,
  input wire logic       uv_fault_in,
  input wire logic       sdo_out,
  input wire logic       sdo_oe_out,
  input wire logic       failsafe_out_n_out,
  input wire logic       failsafe_oe_out,
  input wire logic [1:0] hson_out,
  input wire logic       normal_mode_flag_out,
  input wire dssc_mode_t mode_out
);
  // One clock domain, so one clocking and one disable for all
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_sdo_idle_off : assert property ($past(chip_select_n_in) |-> !sdo_oe_out)
    else $error("serial output driven while deselected");
  a_sdo_need_vdd : assert property (!$past(vdd_ok_in) |-> !sdo_oe_out)
    else $error("serial output driven without interface supply");
  // The output moves one cycle after a detected edge, so two quiet samples of clock and select leave it still
  a_sdo_rise_only : assert property ((!chip_select_n_in && $stable(chip_select_n_in) && $stable(sclk_in)) [*2] |-> $stable(sdo_out))
    else $error("serial output moved without a clock rise");
  a_fs_pin_mode : assert property ($stable(mode_out) |-> failsafe_oe_out == (mode_out == MODE_FAILSAFE))
    else $error("fail-safe pin disagrees with mode");
  a_fs_pin_low : assert property (failsafe_oe_out |-> !failsafe_out_n_out)
    else $error("fail-safe pin not pulled low");
  a_nm_flag : assert property ($stable(mode_out) |-> normal_mode_flag_out == (mode_out == MODE_NORMAL))
    else $error("normal flag disagrees with mode");
  a_sleep_off : assert property ((mode_out == MODE_SLEEP) [*2] |-> hson_out == 2'b00)
    else $error("channel on while asleep");
  a_fault_off : assert property ((mode_out == MODE_FAULT) [*2] |-> hson_out == 2'b00)
    else $error("channel on in fault mode");
  a_fault_entry : assert property (uv_fault_in && reset_in_n_in |-> ##[1:4] mode_out == MODE_FAULT)
    else $error("fault mode not entered");
  a_fs_follow : assert property ((mode_out == MODE_FAILSAFE && $stable(direct_in)) [*4] |-> hson_out == direct_in)
    else $error("fail-safe channels ignore direct inputs");

  // Main scenarios reached
  c_failsafe : cover property (mode_out == MODE_FAILSAFE);
  c_fault : cover property (mode_out == MODE_FAULT);
  c_frame : cover property ($rose(chip_select_n_in));
endmodule // dssc_core_monitor

bind dssc_core dssc_core_monitor #(
  .WD_CYCLES_P(WD_CYCLES_P), .IN_CYCLES_P(IN_CYCLES_P), .WAKE_CYCLES_P(WAKE_CYCLES_P)
) i_monitor (.clock_in, .rst_in, .sclk_in, .chip_select_n_in, .reset_in_n_in, .direct_in, .vdd_ok_in,
  .uv_fault_in, .sdo_out, .sdo_oe_out, .failsafe_out_n_out, .failsafe_oe_out, .hson_out,
  .normal_mode_flag_out, .mode_out);
`default_nettype wire

// [verif/dssc_spi_master.sv]
`timescale 1ns/1ps
`default_nettype none
module dssc_spi_master (
  input  wire logic clock_in,           // System clock
  output logic      sclk_out,           // Serial clock, idle low
  output logic      cs_n_out,           // Chip select, idle high
  output logic      sdi_out,            // Serial data to device
  input  wire logic sdo_in,             // Serial data from device
  input  wire logic sdo_oe_in           // Device drives serial data
);
  // Idle: clock low, deselected, data at its pull-down level
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // Levels change on falling clock edges, away from the sampling edge
  task automatic hold(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // One frame, most significant bit first; three clocks per level keeps the detector happy
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n_out = 1'b0;
    hold(3);
    for (int i = 15; i > 15 - nbits; i--) begin
      rd[i] = sdo_oe_in ? sdo_in : 1'bx;
      sdi_out = word[i];
      sclk_out = 1'b1;
      hold(3);
      sclk_out = 1'b0;
      hold(3);
    end
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
    hold(4);
  endtask
endmodule // dssc_spi_master
`default_nettype wire

// [verif/dssc_core_test.sv]
`timescale 1ns/1ps
`default_nettype none
module dssc_core_test;
  import dssc_pkg::*;
  localparam int WD = 1500;             // Short watchdog window
  localparam int IN = 100;              // Short input idle time
  localparam int WK = 20;               // Short settle time
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        reset_in_n_in = 1'b0;
  logic        vdd_ok_in = 1'b1;
  logic        uv_fault_in = 1'b0;
  logic        wd_bit = 1'b0;           // Watchdog toggle state
  logic [1:0]  direct_in = 2'h0;
  logic        ext_clk = 1'b0;          // External PWM clock
  dssc_chfault_t [1:0] chf = '0;        // Channel fault causes
  logic        sclk, cs_n, sdi, sdo, sdo_oe, fs_n, fs_oe, nm;
  logic [1:0]  hson;
  dssc_mode_t  mode;
  logic [15:0] rd, prev;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #5 clock_in = ~clock_in;

  dssc_core #(.WD_CYCLES_P(WD), .IN_CYCLES_P(IN), .WAKE_CYCLES_P(WK)) i_dut (
    .clock_in(clock_in), .rst_in(rst_in), .sclk_in(sclk), .chip_select_n_in(cs_n), .sdi_in(sdi),
    .reset_in_n_in(reset_in_n_in), .direct_in(direct_in), .ext_pwm_clk_in(ext_clk), .vdd_ok_in(vdd_ok_in),
    .chan_fault_in(chf), .uv_fault_in(uv_fault_in), .ov_fault_in(1'b0), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .failsafe_out_n_out(fs_n), .failsafe_oe_out(fs_oe), .hson_out(hson), .normal_mode_flag_out(nm),
    .mode_out(mode));

  dssc_spi_master i_master (.clock_in(clock_in), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdo_in(sdo), .sdo_oe_in(sdo_oe));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Full frame with the watchdog bit flipped each time
  task automatic send(input logic [3:0] a, input logic [8:0] d);
    wd_bit = ~wd_bit;
    i_master.xfer({wd_bit, 2'h0, a, d}, 16, rd);
  endtask

  // Bounded wait for a mode; running out ends the run
  task automatic wait_mode(input dssc_mode_t m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clock_in);
      n++;
    end
    if (mode !== m) begin
      miscompares++;
      $display("[FAIL] %0t mode timeout got %h exp %h", $time, mode, m);
      stop_test();
    end else begin
      check(16'(mode), 16'(m), "mode");
    end
  endtask

  function automatic logic [1:0] hson_exp(input logic [1:0] din, dis, on, pen);
    return (din & ~dis) | (on & ~pen);
  endfunction

  initial begin
    logic [3:0] a;
    logic [8:0] d;
    logic [1:0] on, pen, dis, din;
    logic [7:0] dty;
    logic [3:0] v;
    int         hi;
    void'($urandom(51664));
    repeat (4) @(negedge clock_in);
    rst_in = 1'b0;
    check(16'(mode), 16'(MODE_SLEEP), "reset mode");
    check({fs_oe, sdo_oe, nm, hson}, 16'h0000, "reset outputs");
    $display("test reset done");
    reset_in_n_in = 1'b1;  // supply already good
    wait_mode(MODE_NORMAL, 10);
    @(negedge clock_in);
    check(nm, 1'b1, "normal flag");
    repeat (WK + 5) @(negedge clock_in);
    send(ADDR_RDSEL, 9'(RB_PWM0));
    send(4'hf, 9'h000);
    check(rd[8:0], 9'h000, "wake clears");
    $display("test wake done");
    send(ADDR_RDSEL, 9'(RB_COUNT));
    prev = {wd_bit, 2'h0, ADDR_RDSEL, 9'(RB_COUNT)};
    for (int i = 0; i < 5; i++) begin
      a = 4'(8 + $urandom_range(7));
      d = 9'($urandom);
      if (i == 4) i_master.xfer(16'hffff, 15, rd);  // short frame dropped
      send(a, d);
      check(rd, prev, "previous frame");
      prev = {wd_bit, 2'h0, a, d};
    end
    $display("test frames done");
    for (int j = 1; j < 5; j++) begin
      d = (j == 1) ? 9'h1ff : 9'($urandom);
      send(4'(j), d);
      send(ADDR_RDSEL, 9'(j));
      send(4'hf, 9'h000);
      check(rd[8:0], d, "register read");
    end
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      {on, pen, dis, din} = (i == 0) ? 8'b0000_1111 : 8'($urandom);
      for (int ch = 0; ch < 2; ch++) begin
        send(4'(ADDR_PWM0 + ch), {on[ch], 8'h00});
        send(4'(ADDR_CONF0 + ch), {6'h00, dis[ch], 1'b0, pen[ch]});
      end
      direct_in = din;
      repeat (5) @(negedge clock_in);
      check(hson, hson_exp(din, dis, on, pen), "switch target");
    end
    $display("test switching done");
    // Over one full counter period the on-steps equal the duty, whatever the start phase and delay
    dty = 8'($urandom);
    send(ADDR_PWM0, {1'b1, dty});
    send(ADDR_CONF0, {2'h0, 2'($urandom), 2'($urandom), 3'b101});
    hi = 0;
    for (int k = 0; k < 256; k++) begin
      ext_clk = 1'b1;
      @(negedge clock_in);
      ext_clk = 1'b0;
      repeat (2) @(negedge clock_in);
      hi += hson[0];
    end
    check(16'(hi), 16'(dty), "external duty");
    $display("test external pwm done");
    // A short fault must stay visible until its register is read
    chf[0] = 4'(1 + $urandom_range(14));
    v = chf[0];
    repeat (2) @(negedge clock_in);
    chf[0] = '0;
    wait_mode(MODE_NORMAL, 10);
    send(ADDR_RDSEL, 9'(RB_FAULT0));
    send(4'hf, 9'h000);
    check(rd[3:0], v, "fault sticky");
    send(4'hf, 9'h000);
    check(rd[3:0], 4'h0, "fault cleared");
    $display("test fault registers done");
    wait_mode(MODE_FAILSAFE, WD + 200);
    check({fs_oe, fs_n}, 2'b10, "fail-safe pin");
    direct_in = 2'b10;
    repeat (6) @(negedge clock_in);
    check(hson, 2'b10, "fail-safe direct");
    $display("test fail-safe done");
    vdd_ok_in = 1'b0;
    uv_fault_in = 1'b1;
    wait_mode(MODE_FAULT, 10);
    repeat (3) @(negedge clock_in);
    check({nm, hson}, 3'b000, "fault off");
    uv_fault_in = 1'b0;
    vdd_ok_in = 1'b1;
    $display("test fault done");
    reset_in_n_in = 1'b0;
    direct_in = 2'b00;
    repeat (IN - 20) @(negedge clock_in);
    check(16'(mode == MODE_SLEEP), 16'h0000, "still awake");
    wait_mode(MODE_SLEEP, 60);
    $display("test sleep done");
    stop_test();
  end
endmodule // dssc_core_test
`default_nettype wire
